/* File: hw/oag_pkg.sv */
package oag_pkg;

    // ==========================================
    // Widths
    localparam int ADDR_W = 23;
    localparam int PAGE_W = 7;
    localparam int LOW_W = 16;
    localparam int OFF_W = 7;
    localparam int PDP_W = 9;
    localparam int BIT_W = 6;
    localparam int NAUX = 8;
    localparam int NACC = 4;
    localparam int NTMP = 4;

    // ==========================================
    // Reset values and limits
    localparam logic [6:0] STACK_PAGE_RST = 7'h00;
    localparam logic [15:0] STACK_PTR_RST = 16'h0000;
    localparam logic [8:0] PDP_RST = 9'h000;
    localparam logic [6:0] AUX_EXT_RST = 7'h00;
    localparam logic [15:0] AUX_LOW_RST = 16'h0000;
    localparam logic [15:0] CDP_RST = 16'h0000;
    localparam logic [6:0] CDP_EXT_RST = 7'h00;
    localparam logic [15:0] BUF_RST = 16'h0000;
    localparam logic COMPAT_RST = 1'b0;
    localparam logic [15:0] MMR_LAST = 16'h005F;
    localparam logic [5:0] ACC_TOP_BIT = 6'h27;
    localparam logic [5:0] REG16_TOP_BIT = 6'h0F;

    // ==========================================
    // Modes
    typedef enum logic [2:0] {
        OAG_DIRECT = 3'h0,
        OAG_REGBIT_DIR = 3'h1,
        OAG_PDP_DIR = 3'h3,
        OAG_AUX_IND = 3'h2,
        OAG_CDP_IND = 3'h6
    } oag_mode_t;

    typedef enum logic [1:0] {
        OAG_ACC_DATA = 2'h0,
        OAG_ACC_BIT = 2'h1,
        OAG_ACC_IO = 2'h2
    } oag_access_t;

    typedef enum logic [1:0] {
        OAG_MOD_NONE = 2'h0,
        OAG_MOD_INC = 2'h1,
        OAG_MOD_DEC = 2'h2
    } oag_modify_t;

    typedef enum logic [1:0] {
        OAG_RCLS_ACC = 2'h0,
        OAG_RCLS_AUX = 2'h1,
        OAG_RCLS_TMP = 2'h2,
        OAG_RCLS_NONE = 2'h3
    } oag_regclass_t;

    // Decoded operand request
    typedef struct packed {
        logic valid;
        oag_mode_t mode;
        oag_access_t access;
        logic [6:0] offset;
        logic [2:0] aux_sel;
        logic [2:0] aux_sel2;
        logic dual;
        oag_modify_t modify;
        logic bit_instr;
        oag_regclass_t reg_class;
    } oag_req_t;

    // Pointer register writes
    typedef struct packed {
        logic wr_stack_page;
        logic wr_stack_ptr;
        logic wr_xsp;
        logic [6:0] stack_page;
        logic [15:0] stack_ptr;
        logic wr_pdp;
        logic [8:0] peripheral_page_reg;
        logic wr_aux_low;
        logic wr_aux_full;
        logic [2:0] aux_wsel;
        logic [22:0] aux_data;
        logic wr_cdp;
        logic [22:0] cdp_data;
        logic wr_compat;
        logic compat;
        logic wr_circ;
        logic [8:0] circ_en;
        logic [15:0] buf_start;
        logic [15:0] buf_size;
    } oag_wr_t;

    // Generated addresses
    typedef struct packed {
        logic data_valid;
        logic [22:0] data_addr;
        logic data2_valid;
        logic [22:0] data2_addr;
        logic coef_valid;
        logic [22:0] coef_addr;
        logic io_valid;
        logic [15:0] io_addr;
        logic bit_valid;
        logic [5:0] bit_pos;
        logic mmr_hit;
        logic bit_error;
    } oag_out_t;

endpackage

/* File: hw/oag_operand_addr_gen.sv */
`timescale 1ns/1ps
module oag_operand_addr_gen #(
    parameter int NAUX = oag_pkg::NAUX
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Decoder request and register writes
    input wire oag_pkg::oag_req_t req,
    input wire oag_pkg::oag_wr_t wr,
    // Data-page direct address from outside this block
    input wire logic [22:0] dp_direct_addr,
    // Generated addresses
    output oag_pkg::oag_out_t addr_out,
    // Pointer state
    output logic [22:0] ext_stack_ptr,
    output logic compat_mode
);

    // ==========================================
    // Pointer registers
    logic [6:0] stack_page_ff;
    logic [15:0] stack_ptr_ff;
    logic [8:0] pdp_ff;
    logic [6:0] aux_ext_ff [NAUX];
    logic [15:0] aux_low_ff [NAUX];
    logic [6:0] cdp_ext_ff;
    logic [15:0] cdp_ff;
    logic compat_ff;
    logic [8:0] circ_en_ff;
    logic [15:0] buf_start_ff;
    logic [15:0] buf_size_ff;
    oag_pkg::oag_out_t out_ff;
    oag_pkg::oag_out_t nxt_out;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            stack_page_ff <= oag_pkg::STACK_PAGE_RST;
            stack_ptr_ff <= oag_pkg::STACK_PTR_RST;
        end else begin
            if (wr.wr_stack_page || wr.wr_xsp) begin
                stack_page_ff <= wr.stack_page;
            end
            if (wr.wr_stack_ptr || wr.wr_xsp) begin
                stack_ptr_ff <= wr.stack_ptr;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pdp_ff <= oag_pkg::PDP_RST;
            compat_ff <= oag_pkg::COMPAT_RST;
            circ_en_ff <= '0;
            buf_start_ff <= oag_pkg::BUF_RST;
            buf_size_ff <= oag_pkg::BUF_RST;
        end else begin
            if (wr.wr_pdp) begin
                pdp_ff <= wr.peripheral_page_reg;
            end
            if (wr.wr_compat) begin
                compat_ff <= wr.compat;
            end
            if (wr.wr_circ) begin
                circ_en_ff <= wr.circ_en;
                buf_start_ff <= wr.buf_start;
                buf_size_ff <= wr.buf_size;
            end
        end
    end

    // ==========================================
    // Circular step helper
    function automatic logic [15:0] step_ptr(input logic [15:0] p, input oag_pkg::oag_modify_t m,
                                             input logic circ, input logic [15:0] sz);
        logic [15:0] r;
        r = p;
        case (m)
            oag_pkg::OAG_MOD_INC: begin
                r = p + 16'h0001;
                if (circ && (r >= sz)) begin
                    r = 16'h0000;
                end
            end
            oag_pkg::OAG_MOD_DEC: begin
                if (circ && (p == 16'h0000) && (sz != 16'h0000)) begin
                    r = sz - 16'h0001;
                end else begin
                    r = p - 16'h0001;
                end
            end
            default: r = p;
        endcase
        return r;
    endfunction

    // Address offset for circular buffers
    function automatic logic [15:0] eff_low(input logic [15:0] p, input logic circ, input logic [15:0] bs);
        return circ ? (p + bs) : p;
    endfunction

    // ==========================================
    // Auxiliary registers
    // eight pointer slots
    genvar gi;
    for (gi = 0; gi < NAUX; gi++) begin : g_aux
        logic sel1;
        logic sel2;
        assign sel1 = req.valid && (req.mode == oag_pkg::OAG_AUX_IND) && (req.aux_sel == 3'(gi));
        assign sel2 = req.valid && (req.mode == oag_pkg::OAG_AUX_IND) && req.dual && (req.aux_sel2 == 3'(gi));
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                aux_ext_ff[gi] <= oag_pkg::AUX_EXT_RST;
                aux_low_ff[gi] <= oag_pkg::AUX_LOW_RST;
            end else if (wr.wr_aux_full && (wr.aux_wsel == 3'(gi))) begin
                aux_ext_ff[gi] <= wr.aux_data[22:16];
                aux_low_ff[gi] <= wr.aux_data[15:0];
            end else if (wr.wr_aux_low && (wr.aux_wsel == 3'(gi))) begin
                aux_low_ff[gi] <= wr.aux_data[15:0];
            end else if (sel1 || sel2) begin
                aux_low_ff[gi] <= step_ptr(aux_low_ff[gi], req.modify, circ_en_ff[gi], buf_size_ff);
            end
        end
    end

    // Coefficient pointer
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cdp_ext_ff <= oag_pkg::CDP_EXT_RST;
            cdp_ff <= oag_pkg::CDP_RST;
        end else if (wr.wr_cdp) begin
            cdp_ext_ff <= wr.cdp_data[22:16];
            cdp_ff <= wr.cdp_data[15:0];
        end else if (req.valid && (req.mode == oag_pkg::OAG_CDP_IND || req.dual)) begin
            cdp_ff <= step_ptr(cdp_ff, req.modify, circ_en_ff[8], buf_size_ff);
        end
    end

    // ==========================================
    // Address formation
    always_comb begin
        logic [15:0] p1;
        logic [15:0] p2;
        logic [15:0] sp_sum;
        logic [5:0] top;
        logic [5:0] bnum;
        logic bit_ok;
        bit_ok = 1'b0;
        p1 = eff_low(aux_low_ff[req.aux_sel], circ_en_ff[req.aux_sel], buf_start_ff);
        p2 = eff_low(aux_low_ff[req.aux_sel2], circ_en_ff[req.aux_sel2], buf_start_ff);
        sp_sum = stack_ptr_ff + {9'h000, req.offset};
        top = (req.reg_class == oag_pkg::OAG_RCLS_ACC) ? oag_pkg::ACC_TOP_BIT : oag_pkg::REG16_TOP_BIT;
        bnum = 6'h00;
        nxt_out = '0;
        case (req.mode)
            oag_pkg::OAG_DIRECT: begin
                nxt_out.data_valid = req.valid;
                if (compat_ff) begin
                    nxt_out.data_addr = {stack_page_ff, sp_sum};
                end else begin
                    nxt_out.data_addr = dp_direct_addr;
                end
            end
            oag_pkg::OAG_REGBIT_DIR: begin
                // offset from LSB
                // Offsets past 63 show 63 so the range check refuses them
                bnum = req.offset[6] ? 6'h3F : req.offset[5:0];
                nxt_out.bit_valid = req.valid;
            end
            oag_pkg::OAG_PDP_DIR: begin
                nxt_out.io_valid = req.valid;
                nxt_out.io_addr = {pdp_ff, req.offset};
            end
            oag_pkg::OAG_AUX_IND: begin
                case (req.access)
                    oag_pkg::OAG_ACC_DATA: begin
                        nxt_out.data_valid = req.valid;
                        nxt_out.data_addr = {aux_ext_ff[req.aux_sel], p1};
                        nxt_out.data2_valid = req.valid && req.dual;
                        nxt_out.data2_addr = {aux_ext_ff[req.aux_sel2], p2};
                        nxt_out.coef_valid = req.valid && req.dual;
                        nxt_out.coef_addr = {cdp_ext_ff, eff_low(cdp_ff, circ_en_ff[8], buf_start_ff)};
                    end
                    oag_pkg::OAG_ACC_BIT: begin
                        bnum = (aux_low_ff[req.aux_sel] > 16'h003F) ? 6'h3F : aux_low_ff[req.aux_sel][5:0];
                        nxt_out.bit_valid = req.valid;
                    end
                    default: begin
                        nxt_out.io_valid = req.valid;
                        nxt_out.io_addr = aux_low_ff[req.aux_sel];
                    end
                endcase
            end
            oag_pkg::OAG_CDP_IND: begin
                case (req.access)
                    oag_pkg::OAG_ACC_DATA: begin
                        nxt_out.data_valid = req.valid;
                        nxt_out.data_addr = {cdp_ext_ff, eff_low(cdp_ff, circ_en_ff[8], buf_start_ff)};
                    end
                    oag_pkg::OAG_ACC_BIT: begin
                        bnum = (cdp_ff > 16'h003F) ? 6'h3F : cdp_ff[5:0];
                        nxt_out.bit_valid = req.valid;
                    end
                    default: begin
                        nxt_out.io_valid = req.valid;
                        nxt_out.io_addr = cdp_ff;
                    end
                endcase
            end
            default: nxt_out = '0;
        endcase
        // bit instructions on allowed registers only
        bit_ok = req.bit_instr && (req.reg_class != oag_pkg::OAG_RCLS_NONE) && (bnum <= top);
        if (nxt_out.bit_valid) begin
            nxt_out.bit_pos = bnum;
            nxt_out.bit_error = !bit_ok;
            nxt_out.bit_valid = bit_ok;
        end
        nxt_out.mmr_hit = nxt_out.data_valid && (nxt_out.data_addr[22:16] == 7'h00)
                          && (nxt_out.data_addr[15:0] <= oag_pkg::MMR_LAST);
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            out_ff <= '0;
        end else begin
            out_ff <= nxt_out;
        end
    end

    assign addr_out = out_ff;
    assign ext_stack_ptr = {stack_page_ff, stack_ptr_ff};
    assign compat_mode = compat_ff;

endmodule // oag_operand_addr_gen

/* File: verification/oag_props.sv */
`timescale 1ns/1ps
// ==========================================
// Checker
module oag_props #(
    parameter int NAUX = oag_pkg::NAUX
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Inputs
    input wire oag_pkg::oag_req_t req,
    input wire oag_pkg::oag_wr_t wr,
    input wire logic [22:0] dp_direct_addr,
    // Outputs
    input wire oag_pkg::oag_out_t addr_out,
    input wire logic [22:0] ext_stack_ptr,
    input wire logic compat_mode
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_direct;
        req.valid && req.mode == oag_pkg::OAG_DIRECT && req.access == oag_pkg::OAG_ACC_DATA;
    endsequence
    sequence s_bit;
        req.valid && req.mode == oag_pkg::OAG_REGBIT_DIR && req.bit_instr;
    endsequence

    a_stack_addr_form: assert property (s_direct ##0 compat_mode |=> addr_out.data_valid &&
        addr_out.data_addr == {$past(ext_stack_ptr[22:16]), $past(ext_stack_ptr[15:0]) + 16'($past(req.offset))})
        else $error("stack address wrong");
    a_page_direct_sel: assert property (s_direct ##0 !compat_mode |=>
        addr_out.data_addr == $past(dp_direct_addr)) else $error("data page address wrong");
    a_pdp_io_form: assert property (req.valid && req.mode == oag_pkg::OAG_PDP_DIR |=>
        addr_out.io_valid && addr_out.io_addr[6:0] == $past(req.offset)) else $error("io address wrong");
    a_mmr_flag_range: assert property (addr_out.data_valid |->
        addr_out.mmr_hit == (addr_out.data_addr <= 23'h00005F)) else $error("mmr flag wrong");
    a_bit_refuse: assert property (req.valid && req.mode == oag_pkg::OAG_REGBIT_DIR && !req.bit_instr |=>
        !addr_out.bit_valid && addr_out.bit_error) else $error("bit access not refused");
    a_acc_bit_pos: assert property (s_bit ##0 (req.reg_class == oag_pkg::OAG_RCLS_ACC && req.offset <= 7'h27)
        |=> addr_out.bit_valid && {1'b0, addr_out.bit_pos} == $past(req.offset)) else $error("bit position wrong");
    a_reg16_limit: assert property (s_bit ##0 (req.reg_class inside {oag_pkg::OAG_RCLS_AUX,
        oag_pkg::OAG_RCLS_TMP} && req.offset > 7'h0F) |=> addr_out.bit_error && !addr_out.bit_valid)
        else $error("short register limit missed");
    a_xsp_load: assert property (wr.wr_xsp |=>
        ext_stack_ptr == {$past(wr.stack_page), $past(wr.stack_ptr)}) else $error("extended pointer load wrong");
    a_compat_load: assert property (wr.wr_compat |=> compat_mode == $past(wr.compat))
        else $error("compat bit load wrong");
endmodule // oag_props

bind oag_operand_addr_gen oag_props #(.NAUX(NAUX)) u_props (.clock(clock), .rst(rst), .req(req), .wr(wr),
    .dp_direct_addr(dp_direct_addr), .addr_out(addr_out), .ext_stack_ptr(ext_stack_ptr), .compat_mode(compat_mode));

/* File: verification/oag_bus_model.sv */
`timescale 1ns/1ps
// ==========================================
// I/O bus sink: counts I/O accesses
module oag_bus_model (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Address bus
    input wire oag_pkg::oag_out_t bus,
    // Count
    output logic [7:0] io_cnt_ff
);
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            io_cnt_ff <= 8'h00;
        end else if (bus.io_valid) begin
            io_cnt_ff <= io_cnt_ff + 8'h01;
        end
    end
endmodule // oag_bus_model

/* File: verification/oag_operand_addr_gen_test.sv */
`timescale 1ns/1ps
// ==========================================
// Testbench
module oag_operand_addr_gen_test;
    logic clock;
    logic rst;
    oag_pkg::oag_req_t req;
    oag_pkg::oag_wr_t wr;
    logic [22:0] dp_direct_addr;
    oag_pkg::oag_out_t addr_out;
    logic [22:0] ext_stack_ptr;
    logic compat_mode;
    logic [7:0] io_cnt;
    oag_pkg::oag_wr_t w;
    oag_pkg::oag_req_t r;
    int fails = 0;
    int samples_checked = 0;

    oag_operand_addr_gen #(.NAUX(oag_pkg::NAUX)) dut (.clock(clock), .rst(rst), .req(req), .wr(wr),
        .dp_direct_addr(dp_direct_addr), .addr_out(addr_out), .ext_stack_ptr(ext_stack_ptr),
        .compat_mode(compat_mode));
    oag_bus_model bus (.clock(clock), .rst(rst), .bus(addr_out), .io_cnt_ff(io_cnt));

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // ==========================================
    // Helpers
    task automatic chk(input logic [22:0] got, input logic [22:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wrt();
        @(posedge clock);
        wr <= w;
        @(posedge clock);
        wr <= '0;
        #1;
        w = '0;
    endtask
    function automatic void set(oag_pkg::oag_mode_t m, oag_pkg::oag_access_t a, logic [6:0] o, logic [2:0] s);
        r = '0;
        r.valid = 1'b1;
        r.mode = m;
        r.access = a;
        r.offset = o;
        r.aux_sel = s;
        r.bit_instr = 1'b1;
    endfunction
    task automatic go();
        @(posedge clock);
        req <= r;
        @(posedge clock);
        req <= '0;
        #1;
    endtask
    task automatic stk(input logic [6:0] o, input logic [22:0] e, input logic m);
        set(oag_pkg::OAG_DIRECT, oag_pkg::OAG_ACC_DATA, o, 3'h0);
        go();
        chk(addr_out.data_addr, e);
        chk(addr_out.mmr_hit, m);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ==========================================
    // Scenarios
    task automatic t_stack();
        w.wr_compat = 1'b1;
        w.compat = 1'b1;
        wrt();
        w.wr_xsp = 1'b1;
        w.stack_page = 7'h03;
        w.stack_ptr = 16'hFFF0;
        wrt();
        chk(ext_stack_ptr, 23'h03FFF0);
        stk(7'h10, 23'h030000, 1'b0);
        stk(7'h7F, 23'h03006F, 1'b0);
        stk(7'h00, 23'h03FFF0, 1'b0);
        w.wr_stack_page = 1'b1;
        wrt();
        w.wr_stack_ptr = 1'b1;
        w.stack_ptr = 16'h0050;
        wrt();
        chk(ext_stack_ptr, 23'h000050);
        stk(7'h0F, 23'h00005F, 1'b1);
        stk(7'h10, 23'h000060, 1'b0);
        $display("t_stack done");
    endtask
    task automatic t_dp();
        w.wr_compat = 1'b1;
        wrt();
        chk(compat_mode, 1'b0);
        @(posedge clock);
        dp_direct_addr <= 23'h123456;
        set(oag_pkg::OAG_DIRECT, oag_pkg::OAG_ACC_DATA, 7'h05, 3'h0);
        go();
        chk(addr_out.data_addr, 23'h123456);
        $display("t_dp done");
    endtask
    task automatic t_regbit();
        logic [1:0] cl [9] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h0};
        logic [6:0] of [9] = '{7'h00, 7'h03, 7'h27, 7'h28, 7'h0F, 7'h10, 7'h00, 7'h01, 7'h41};
        logic [8:0] ok = 9'h017;
        for (int i = 0; i < 9; i++) begin
            set(oag_pkg::OAG_REGBIT_DIR, oag_pkg::OAG_ACC_BIT, of[i], 3'h0);
            r.reg_class = oag_pkg::oag_regclass_t'(cl[i]);
            r.bit_instr = (i != 7);
            go();
            chk(addr_out.bit_valid, ok[i]);
            chk(addr_out.bit_error, !ok[i]);
            if (ok[i]) chk(addr_out.bit_pos, of[i]);
        end
        $display("t_regbit done");
    endtask
    task automatic t_pdp();
        w.wr_pdp = 1'b1;
        w.peripheral_page_reg = 9'h1FF;
        wrt();
        set(oag_pkg::OAG_PDP_DIR, oag_pkg::OAG_ACC_IO, 7'h7F, 3'h0);
        go();
        chk(addr_out.io_addr, 16'hFFFF);
        w.wr_pdp = 1'b1;
        w.peripheral_page_reg = 9'h001;
        wrt();
        set(oag_pkg::OAG_PDP_DIR, oag_pkg::OAG_ACC_IO, 7'h00, 3'h0);
        go();
        chk(addr_out.io_addr, 16'h0080);
        $display("t_pdp done");
    endtask
    task automatic t_aux();
        for (int i = 0; i < 8; i++) begin
            w.wr_aux_full = 1'b1;
            w.aux_wsel = 3'(i);
            w.aux_data = {7'(i + 1), 16'(i * 16'h1111)};
            wrt();
        end
        for (int i = 0; i < 8; i++) begin
            set(oag_pkg::OAG_AUX_IND, oag_pkg::OAG_ACC_DATA, 7'h00, 3'(i));
            go();
            chk(addr_out.data_addr, {7'(i + 1), 16'(i * 16'h1111)});
        end
        w.wr_cdp = 1'b1;
        w.cdp_data = 23'h2A5A5A;
        wrt();
        set(oag_pkg::OAG_AUX_IND, oag_pkg::OAG_ACC_DATA, 7'h00, 3'h1);
        r.aux_sel2 = 3'h6;
        r.dual = 1'b1;
        go();
        chk(addr_out.data_addr, 23'h021111);
        chk(addr_out.data2_addr, 23'h076666);
        chk(addr_out.coef_addr, 23'h2A5A5A);
        chk(addr_out.data2_valid, 1'b1);
        chk(addr_out.coef_valid, 1'b1);
        set(oag_pkg::OAG_CDP_IND, oag_pkg::OAG_ACC_DATA, 7'h00, 3'h0);
        r.modify = oag_pkg::OAG_MOD_DEC;
        go();
        chk(addr_out.data_addr, 23'h2A5A5A);
        chk(addr_out.data_valid, 1'b1);
        set(oag_pkg::OAG_CDP_IND, oag_pkg::OAG_ACC_IO, 7'h00, 3'h0);
        go();
        chk(addr_out.io_addr, 16'h5A59);
        set(oag_pkg::OAG_AUX_IND, oag_pkg::OAG_ACC_IO, 7'h00, 3'h5);
        go();
        chk(addr_out.io_addr, 16'h5555);
        w.wr_aux_low = 1'b1;
        w.aux_data = 23'h000021;
        wrt();
        set(oag_pkg::OAG_AUX_IND, oag_pkg::OAG_ACC_DATA, 7'h00, 3'h0);
        go();
        chk(addr_out.data_addr, 23'h010021);
        set(oag_pkg::OAG_AUX_IND, oag_pkg::OAG_ACC_BIT, 7'h00, 3'h0);
        go();
        chk(addr_out.bit_pos, 6'h21);
        w.wr_aux_full = 1'b1;
        w.aux_wsel = 3'h3;
        w.aux_data = 23'h7AFFFF;
        wrt();
        set(oag_pkg::OAG_AUX_IND, oag_pkg::OAG_ACC_DATA, 7'h00, 3'h3);
        r.modify = oag_pkg::OAG_MOD_INC;
        go();
        chk(addr_out.data_addr, 23'h7AFFFF);
        r.modify = oag_pkg::OAG_MOD_NONE;
        go();
        chk(addr_out.data_addr, 23'h7A0000);
        $display("t_aux done");
    endtask
    task automatic t_circ();
        w.wr_circ = 1'b1;
        w.circ_en = 9'h008;
        w.buf_start = 16'h1000;
        w.buf_size = 16'h0004;
        wrt();
        w.wr_aux_full = 1'b1;
        w.aux_wsel = 3'h3;
        w.aux_data = 23'h000003;
        wrt();
        set(oag_pkg::OAG_AUX_IND, oag_pkg::OAG_ACC_DATA, 7'h00, 3'h3);
        r.modify = oag_pkg::OAG_MOD_INC;
        go();
        chk(addr_out.data_addr, 23'h001003);
        r.modify = oag_pkg::OAG_MOD_NONE;
        go();
        chk(addr_out.data_addr, 23'h001000);
        $display("t_circ done");
    endtask

    // ==========================================
    // Main sequence and watchdog
    initial begin
        rst = 1'b1;
        req = '0;
        wr = '0;
        w = '0;
        r = '0;
        dp_direct_addr = '0;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        t_stack();
        t_dp();
        t_regbit();
        t_pdp();
        t_aux();
        t_circ();
        chk(io_cnt, 8'h04);
        test_done();
    end
    initial begin
        repeat (5000) @(posedge clock);
        fails++;
        test_done();
    end
endmodule // oag_operand_addr_gen_test
